// File: src/fsp_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two; full and empty come from pointer compare.
`timescale 1ns/1ps
`default_nettype none
module fsp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wr;
        logic [AW:0]             rd;
    } fsp_fifo_state_t;

    fsp_fifo_state_t s;
    fsp_fifo_state_t next_s;
    logic            push;
    logic            pop;

    assign in_ready  = !((s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]));
    assign out_valid = (s.wr != s.rd);
    assign out_data  = s.mem[s.rd[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wr[AW-1:0]] = in_data;
            next_s.wr = s.wr + 1'b1;
        end
        if (pop)
        begin
            next_s.rd = s.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// File: src/fsp_pkg.sv
// Shared constants for the fast settling postfilter and its output buffer.
// Assumes one system clock; the master clock arrives as one sample strobe per period.
package fsp_pkg;

    // Master clock reference for all rate and notch figures.
    localparam int MCLK_HZ    = 4_920_000;
    localparam int CLK_SYS_HZ = 100_000_000;

    // Rate word and decimation layout.
    localparam int FS_W        = 10;
    localparam int DECIM_SHIFT = 10;
    localparam int TICK_W      = FS_W + DECIM_SHIFT;
    localparam logic [DECIM_SHIFT-1:0] TICK_LOW_END = 10'h3ff;
    localparam logic [FS_W-1:0]        FS_MIN       = 10'h001;
    localparam logic [FS_W-1:0]        FS_SIXTH_DIV = 10'h006;

    // Sinc order choices.
    localparam logic [4:0] ORDER_SINC4 = 5'h04;
    localparam logic [4:0] ORDER_SINC3 = 5'h03;
    localparam int         MAX_ORDER   = 4;

    // Averaging selection codes, factors and shifts.
    localparam logic [1:0] AVG_SEL_OFF = 2'h0;
    localparam logic [1:0] AVG_SEL_2   = 2'h1;
    localparam logic [1:0] AVG_SEL_8   = 2'h2;
    localparam logic [1:0] AVG_SEL_16  = 2'h3;
    localparam logic [4:0] AVG_N_2     = 5'h02;
    localparam logic [4:0] AVG_N_8     = 5'h08;
    localparam logic [4:0] AVG_N_16    = 5'h10;
    localparam int         AVG_SH_2    = 1;
    localparam int         AVG_SH_8    = 3;
    localparam int         AVG_SH_16   = 4;
    localparam int         AVG_SH_MAX  = 4;

    // Data widths: sinc growth is order times log2 of the decimation, plus sign.
    localparam int ACC_W = MAX_ORDER * TICK_W + 1;
    localparam int SUM_W = ACC_W + AVG_SH_MAX + 1;

    // Output buffer.
    localparam int FIFO_DEPTH = 16;

    // Values after reset.
    localparam logic [TICK_W-1:0] TICK_RST  = 20'h0_0000;
    localparam logic [4:0]        NSINC_RST = 5'h00;

    typedef enum logic [1:0] {S_OFF, S_RUN, S_PUSH} fsp_phase_t;

endpackage

// File: src/fsp_postfilter.sv
// Fast settling decimation filter: sinc4 or sinc3 stage, averaging postfilter, output FIFO.
// Assumes one modulator bit per master clock period, offered with mod_valid.
// Overview of operation
// - Nonzero averaging selection switches fast settling operation on.
// - Both selection bits zero: no fast settling, no fast settling rate.
// - Postfilter averages 2, 8 or 16 consecutive sinc results as selected.
// - Ten-bit rate word is read as an unsigned integer.
// - Chop off: output period is (order + average - 1) x 1024 x rate word clocks.
// - Each result settles within one output period, same for one or many channels.
// - Channel change adds no delay; first conversion after it is valid.
// - Converting continues through input steps; unaligned step gives one unsettled result.
// - Chop on keeps the output rate but takes two periods to settle.
// - Sinc notch at clock/(1024 x rate word); postfilter adds notches at that over average.
// - Rate word 96, average 16, dual mains bit: add 60 Hz notch, lower rate.
// - Master clock is nominally 4.92 MHz, reference for all rates and notches.
`timescale 1ns/1ps
`default_nettype none
module fsp_postfilter #(
    parameter int DEPTH = fsp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // Modulator bitstream, one bit per master clock period
    input  wire logic                       mod_valid,
    input  wire logic                       mod_bit,
    output logic                            mod_ready,
    // Configuration
    input  wire logic                       postfilter_average_select_hi,
    input  wire logic                       postfilter_average_select_lo,
    input  wire logic [fsp_pkg::FS_W-1:0]   rate_divisor_word,
    input  wire logic                       sinc3_select,
    input  wire logic                       chop_enable,
    input  wire logic                       dual_mains_notch,
    input  wire logic                       channel_change,
    // Status
    output logic                            fast_settling_active,
    // Result stream
    output logic                            result_valid,
    input  wire logic                       result_ready,
    output logic [fsp_pkg::ACC_W-1:0]       result_data
);
    localparam int ACC_W  = fsp_pkg::ACC_W;
    localparam int SUM_W  = fsp_pkg::SUM_W;
    localparam int FS_W   = fsp_pkg::FS_W;
    localparam int TICK_W = fsp_pkg::TICK_W;
    localparam int NST    = fsp_pkg::MAX_ORDER;

    typedef struct packed {
        fsp_pkg::fsp_phase_t     phase;
        logic [NST-1:0][ACC_W-1:0] integ;
        logic [NST-1:0][ACC_W-1:0] cdly;
        logic [TICK_W-1:0]       tick;
        logic [4:0]              nsinc;
        logic [SUM_W-1:0]        acc;
        logic [ACC_W-1:0]        first;
        logic                    pass2;
        logic [ACC_W-1:0]        prev;
        logic                    prev_ok;
        logic                    pol;
        logic [FS_W-1:0]         cfg_fs;
        logic [FS_W-1:0]         cur_fs;
        logic [1:0]              cfg_avg;
        logic                    cfg_sinc3;
        logic                    cfg_chop;
        logic                    cfg_rej;
        logic [ACC_W-1:0]        res;
    } fsp_state_t;

    fsp_state_t       s;
    fsp_state_t       next_s;
    logic [1:0]       avg_sel;
    logic             fast_on;
    logic             fifo_in_ready;

    assign avg_sel = {postfilter_average_select_hi, postfilter_average_select_lo};
    assign fast_on = (avg_sel != fsp_pkg::AVG_SEL_OFF);

    function automatic logic [4:0] avg_count(input logic [1:0] code);
        case (code)
            fsp_pkg::AVG_SEL_2:  avg_count = fsp_pkg::AVG_N_2;
            fsp_pkg::AVG_SEL_8:  avg_count = fsp_pkg::AVG_N_8;
            fsp_pkg::AVG_SEL_16: avg_count = fsp_pkg::AVG_N_16;
            default:             avg_count = fsp_pkg::AVG_N_2;
        endcase
    endfunction

    // Divides the window sum by the averaging factor with an arithmetic shift.
    function automatic logic [SUM_W-1:0] avg_div(input logic [1:0] code, input logic [SUM_W-1:0] a);
        case (code)
            fsp_pkg::AVG_SEL_2:  avg_div = SUM_W'($signed(a) >>> fsp_pkg::AVG_SH_2);
            fsp_pkg::AVG_SEL_8:  avg_div = SUM_W'($signed(a) >>> fsp_pkg::AVG_SH_8);
            fsp_pkg::AVG_SEL_16: avg_div = SUM_W'($signed(a) >>> fsp_pkg::AVG_SH_16);
            default:             avg_div = a;
        endcase
    endfunction

    // Clears the sinc stage and the averager for a fresh window at the given rate word.
    function automatic fsp_state_t clear_window(input fsp_state_t a, input logic [FS_W-1:0] fs);
        fsp_state_t r;
        r       = a;
        // Every window starts from empty integrators and combs, so no history leaks in.
        r.integ = '0;
        r.cdly  = '0;
        r.tick  = fsp_pkg::TICK_RST;
        r.nsinc = fsp_pkg::NSINC_RST;
        r.acc   = '0;
        r.cur_fs = (fs == '0) ? fsp_pkg::FS_MIN : fs;
        return r;
    endfunction

    // Latches the configuration and opens a new conversion.
    function automatic fsp_state_t start_conv(input fsp_state_t a);
        fsp_state_t r;
        r           = a;
        r.phase     = fsp_pkg::S_RUN;
        r.cfg_avg   = avg_sel;
        r.cfg_sinc3 = sinc3_select;
        r.cfg_chop  = chop_enable;
        r.cfg_rej   = dual_mains_notch;
        // A rate word of zero would give an empty window, so it runs as one.
        r.cfg_fs    = (rate_divisor_word == '0) ? fsp_pkg::FS_MIN : rate_divisor_word;
        r.pass2     = 1'b0;
        return clear_window(r, r.cfg_fs);
    endfunction

    always_comb
    begin
        logic [ACC_W-1:0] v;
        logic [ACC_W-1:0] d;
        logic [4:0]       ord;
        logic [4:0]       k;
        logic [SUM_W-1:0] sum;
        logic [ACC_W-1:0] pr;
        logic [ACC_W:0]   two;
        logic [ACC_W-1:0] fin;
        logic [FS_W-1:0]  fs60;
        v      = '0;
        d      = '0;
        ord    = s.cfg_sinc3 ? fsp_pkg::ORDER_SINC3 : fsp_pkg::ORDER_SINC4;
        k      = s.nsinc + 5'h01;
        sum    = '0;
        pr     = '0;
        two    = '0;
        fin    = '0;
        // Rate word of the second window used by the dual mains notch.
        fs60   = s.cfg_fs - (s.cfg_fs / fsp_pkg::FS_SIXTH_DIV);
        next_s = s;
        case (s.phase)
            fsp_pkg::S_OFF:
            begin
                if (fast_on)
                begin
                    next_s = start_conv(s);
                end
            end
            fsp_pkg::S_RUN:
            begin
                if (mod_valid)
                begin
                    // A one enters the integrators as +1 and a zero as -1.
                    // chop swaps the input polarity each conversion
                    v = (mod_bit ^ s.pol) ? ACC_W'(1) : '1;
                    for (int i = 0; i < NST; i++)
                    begin
                        if (i < int'(ord))
                        begin
                            next_s.integ[i] = s.integ[i] + v;
                            v = next_s.integ[i];
                        end
                    end
                    next_s.tick = s.tick + 1'b1;
                    // sinc period of 1024 x rate word master clocks
                    // one tick per master clock period
                    if (s.tick == {s.cur_fs - 1'b1, fsp_pkg::TICK_LOW_END})
                    begin
                        next_s.tick  = fsp_pkg::TICK_RST;
                        next_s.nsinc = k;
                        for (int i = 0; i < NST; i++)
                        begin
                            if (i < int'(ord))
                            begin
                                d = v - s.cdly[i];
                                next_s.cdly[i] = v;
                                v = d;
                            end
                        end
                        // average the settled sinc results only
                        if (k >= ord)
                        begin
                            sum = s.acc + {{(SUM_W-ACC_W){v[ACC_W-1]}}, v};
                            next_s.acc = sum;
                        end
                        // window ends after order + average - 1 sinc results
                        if (k == ord + avg_count(s.cfg_avg) - 5'h01)
                        begin
                            pr = ACC_W'(avg_div(s.cfg_avg, sum));
                            // second window at five sixths of the rate word
                            if (s.cfg_rej && !s.pass2)
                            begin
                                next_s = clear_window(next_s, fs60);
                                next_s.first = pr;
                                next_s.pass2 = 1'b1;
                            end
                            else
                            begin
                                two = s.cfg_rej ? ({pr[ACC_W-1], pr} + {s.first[ACC_W-1], s.first})
                                                : {pr, 1'b0};
                                fin = two[ACC_W:1];
                                if (s.pol)
                                begin
                                    fin = -fin;
                                end
                                next_s.phase = fsp_pkg::S_PUSH;
                                next_s.res   = fin;
                                if (s.cfg_chop)
                                begin
                                    two = {fin[ACC_W-1], fin} + {s.prev[ACC_W-1], s.prev};
                                    next_s.res     = two[ACC_W:1];
                                    next_s.prev    = fin;
                                    next_s.prev_ok = 1'b1;
                                    next_s.pol     = !s.pol;
                                    if (!s.prev_ok)
                                    begin
                                        next_s = start_conv(next_s);
                                    end
                                end
                            end
                        end
                    end
                end
            end
            fsp_pkg::S_PUSH:
            begin
                // every conversion starts from a cleared filter
                // next conversion starts once the buffer takes the result
                if (fifo_in_ready)
                begin
                    next_s = start_conv(s);
                end
            end
            default:
            begin
                next_s.phase = fsp_pkg::S_OFF;
            end
        endcase
        // channel change restarts the conversion at once
        if (channel_change && fast_on)
        begin
            next_s         = start_conv(s);
            next_s.prev_ok = 1'b0;
            next_s.pol     = 1'b0;
        end
        // fast settling off when both bits are zero
        if (!fast_on)
        begin
            next_s.phase   = fsp_pkg::S_OFF;
            next_s.prev_ok = 1'b0;
            next_s.pol     = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s       <= '0;
            s.phase <= fsp_pkg::S_OFF;
            // Smallest legal rate word, so the tick compare never sees zero.
            s.cur_fs <= fsp_pkg::FS_MIN;
            s.cfg_fs <= fsp_pkg::FS_MIN;
        end
        else
        begin
            s <= next_s;
        end
    end

    // The bitstream is held off only while a result waits to enter the buffer.
    assign mod_ready            = (s.phase != fsp_pkg::S_PUSH);
    assign fast_settling_active = (s.phase != fsp_pkg::S_OFF);

    // Results wait here; a full buffer stalls the bitstream rather than drop a result.
    fsp_fifo #(
        .W     (ACC_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (s.phase == fsp_pkg::S_PUSH),
        .in_ready  (fifo_in_ready),
        .in_data   (s.res),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (result_data)
    );
endmodule
`default_nettype wire

// File: testbench/fast_settling_postfilter_test.sv
// Self-checking bench for the fast settling postfilter.
// Assumes a two-entry buffer so a full stall is reached quickly.
`timescale 1ns/1ps
`default_nettype none
module fast_settling_postfilter_test;
    localparam int W = fsp_pkg::ACC_W;
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    logic [1:0]   sel = 2'h1;
    logic [9:0]   fs = 10'h001;
    logic         s3 = 1'b1;
    logic         chop = 1'b0;
    logic         dm = 1'b0;
    logic         cc = 1'b0;
    logic         rr = 1'b1;
    logic         lvl = 1'b1;
    logic         pause = 1'b0;
    logic         mv, mb, mr, fsa, rv;
    logic [W-1:0] rd;
    int           fail_count = 0;
    int           n_tests = 0;
    int           cyc = 0;

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    fsp_mod_src u_src (.clk_sys(clk_sys), .rst(rst), .level(lvl), .pause(pause),
        .mod_ready(mr), .mod_valid(mv), .mod_bit(mb));

    fsp_postfilter #(.DEPTH(2)) uut (.clk_sys(clk_sys), .rst(rst), .mod_valid(mv),
        .mod_bit(mb), .mod_ready(mr), .postfilter_average_select_hi(sel[1]),
        .postfilter_average_select_lo(sel[0]), .rate_divisor_word(fs), .sinc3_select(s3),
        .chop_enable(chop), .dual_mains_notch(dm), .channel_change(cc),
        .fast_settling_active(fsa), .result_valid(rv), .result_ready(rr), .result_data(rd));

    task automatic close_out;
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [W-1:0] e, input logic [W-1:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // Settled value of a constant input: the raw sinc gain with the input's sign.
    function automatic logic [W-1:0] ev(input int o, input int f, input logic n);
        logic [W-1:0] v;
        v = 1;
        repeat (o) v = v * (W'(f) << 10);
        return n ? -v : v;
    endfunction

    task automatic wait_res(output logic [W-1:0] d, output int c);
        c = 0;
        do
        begin
            @(negedge clk_sys);
            c++;
        end
        while (rv !== 1'b1 && c < 40000);
        d = rd;
        chk("result wait", 1'b1, rv);
    endtask

    // Called just after a result, so the new settings and input land early in a conversion.
    task automatic conv(input logic [1:0] s, input logic o3, input int f, input logic ch,
        input logic d, input int k);
        logic [W-1:0] r;
        int           c;
        int           n;
        int           fe;
        fe = (f == 0) ? 1 : f;
        n = ((o3 ? 2 : 3) + (s == 2'h1 ? 2 : (s == 2'h2 ? 8 : 16))) * 1024 * fe * k;
        {sel, s3, chop, dm} = {s, o3, ch, d};
        fs = f[9:0];
        lvl = !lvl;
        @(negedge clk_sys);
        cc = 1'b1;
        @(negedge clk_sys);
        cc = 1'b0;
        wait_res(r, c);
        chk("first result", ev(o3 ? 3 : 4, fe, !lvl), r);
        chk("result cycles", n + 1, c);
    endtask

    task automatic sc_rates;
        conv(2'h1, 1'b1, 0, 1'b0, 1'b0, 1);
        conv(2'h2, 1'b0, 1, 1'b0, 1'b0, 1);
        conv(2'h3, 1'b1, 1, 1'b0, 1'b0, 1);
        conv(2'h1, 1'b1, 2, 1'b0, 1'b0, 1);
    endtask

    task automatic sc_chop;
        logic [W-1:0] r;
        int           c;
        conv(2'h1, 1'b1, 1, 1'b1, 1'b0, 2);
        wait_res(r, c);
        chk("chop period", 4097, c);
    endtask

    task automatic sc_dual;
        conv(2'h1, 1'b1, 1, 1'b0, 1'b1, 2);
    endtask

    task automatic sc_step;
        logic [W-1:0] r;
        int           c;
        conv(2'h1, 1'b1, 1, 1'b0, 1'b0, 1);
        repeat (1000) @(negedge clk_sys);
        lvl = !lvl;
        wait_res(r, c);
        chk("step partial", 1'b0, r === ev(3, 1, 1'b0) || r === ev(3, 1, 1'b1));
        wait_res(r, c);
        chk("step settled", ev(3, 1, !lvl), r);
        chk("step period", 4097, c);
    endtask

    task automatic sc_fifo;
        logic [W-1:0] r;
        int           c;
        rr = 1'b0;
        pause = 1'b1;
        repeat (200) @(negedge clk_sys);
        pause = 1'b0;
        repeat (8800) @(negedge clk_sys);
        chk("full stall", 2'b01, {mr, rv});
        rr = 1'b1;
        repeat (3)
        begin
            wait_res(r, c);
            chk("drained value", ev(3, 1, !lvl), r);
        end
        @(negedge clk_sys);
        chk("drained empty", 1'b0, rv);
    endtask

    task automatic sc_off;
        logic seen;
        seen = 1'b0;
        sel = 2'h0;
        repeat (2) @(negedge clk_sys);
        chk("idle state", 2'b10, {mr, fsa});
        repeat (4200)
        begin
            @(negedge clk_sys);
            seen = seen | rv;
        end
        chk("idle results", 1'b0, seen);
        sel = 2'h3;
        repeat (2) @(negedge clk_sys);
        chk("active again", 1'b1, fsa);
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            fail_count++;
            $display("MISMATCH cycle_limit expected %0d seen %0d", 99999, cyc);
            close_out;
        end
    end

    initial
    begin
        logic [W-1:0] r;
        int           c;
        repeat (16) @(negedge clk_sys);
        chk("reset state", 3'b010, {rv, mr, fsa});
        rst = 1'b0;
        wait_res(r, c);
        chk("first value", ev(3, 1, 1'b0), r);
        sc_rates;
        sc_chop;
        sc_dual;
        sc_step;
        sc_fifo;
        sc_off;
        close_out;
    end
endmodule
`default_nettype wire

// File: testbench/fsp_mod_src.sv
// Modulator bitstream source for the postfilter bench.
// Assumes the bench sets the input level and the pause request.
`timescale 1ns/1ps
`default_nettype none
module fsp_mod_src (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Control from the bench
    input  wire logic level,
    input  wire logic pause,
    // Bitstream
    input  wire logic mod_ready,
    output logic      mod_valid,
    output logic      mod_bit
);
    // A bit is held until taken; a paused line toggles so no stale value shows.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mod_valid <= 1'b0;
            mod_bit   <= 1'b0;
        end
        else if (!mod_valid || mod_ready)
        begin
            mod_valid <= !pause;
            mod_bit   <= pause ? !mod_bit : level;
        end
    end
endmodule
`default_nettype wire

// File: testbench/fsp_postfilter_chk.sv
// Port checker for the fast settling postfilter.
// Assumes one clock domain; the bind at the foot attaches it to every instance.
`timescale 1ns/1ps
`default_nettype none
module fsp_postfilter_chk (
    // Clock and reset
    input wire logic                      clk_sys,
    input wire logic                      rst,
    // Bitstream and configuration
    input wire logic                      mod_valid,
    input wire logic                      mod_ready,
    input wire logic                      postfilter_average_select_hi,
    input wire logic                      postfilter_average_select_lo,
    input wire logic [fsp_pkg::FS_W-1:0]  rate_divisor_word,
    input wire logic                      sinc3_select,
    input wire logic                      chop_enable,
    input wire logic                      dual_mains_notch,
    input wire logic                      channel_change,
    // Status and results
    input wire logic                      fast_settling_active,
    input wire logic                      result_valid,
    input wire logic                      result_ready,
    input wire logic [fsp_pkg::ACC_W-1:0] result_data
);
    logic [1:0]  sel;
    logic [31:0] n_bits;
    logic        dirty;
    int          n_exp;

    assign sel = {postfilter_average_select_hi, postfilter_average_select_lo};

    always_comb
    begin
        n_exp = (sinc3_select ? 2 : 3) + (sel == 2'h1 ? 2 : (sel == 2'h2 ? 8 : 16));
        n_exp = (n_exp << 10) * ((rate_divisor_word == 10'h000) ? 1 : int'(rate_divisor_word));
    end

    // A conversion is judged only if nothing disturbed it since the previous push.
    always_ff @(posedge clk_sys)
    begin
        if (rst || !fast_settling_active || channel_change || chop_enable || dual_mains_notch
            || $changed({sel, rate_divisor_word, sinc3_select}))
            dirty <= 1'b1;
        else if (!mod_ready)
            dirty <= 1'b0;
        if (rst || !mod_ready)
            n_bits <= 32'h0000_0000;
        else if (mod_valid && fast_settling_active)
            n_bits <= n_bits + 32'h0000_0001;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence push_into_empty;
        $fell(mod_ready) && !result_valid && (sel != 2'h0) && !chop_enable;
    endsequence

    sequence drained_stall;
        result_ready [*2] ##0 !mod_ready;
    endsequence

    AST_ON: assert property ((sel != 2'h0) |=> fast_settling_active)
        else $error("fast settling not active");
    AST_OFF: assert property ((sel == 2'h0) |=> !fast_settling_active)
        else $error("fast settling active with zero select");
    AST_IDLE_READY: assert property (!fast_settling_active |=> mod_ready)
        else $error("bitstream refused while idle");
    AST_NO_OUT_OFF: assert property ((!fast_settling_active) [*2] ##0 !result_valid
        |=> !result_valid)
        else $error("result produced while idle");
    AST_PERIOD: assert property (($fell(mod_ready) && !dirty) |-> (n_bits == n_exp))
        else $error("wrong bit count per conversion");
    AST_PUSH: assert property (push_into_empty |=> (mod_ready && result_valid))
        else $error("push did not reach the result stream");
    AST_DRAIN: assert property (drained_stall |=> mod_ready)
        else $error("bitstream stalled with space in buffer");
    AST_HOLD: assert property ((result_valid && !result_ready)
        |=> (result_valid && $stable(result_data)))
        else $error("waiting result changed");
endmodule

bind fsp_postfilter fsp_postfilter_chk u_chk (
    .clk_sys, .rst, .mod_valid, .mod_ready, .postfilter_average_select_hi,
    .postfilter_average_select_lo, .rate_divisor_word, .sinc3_select, .chop_enable,
    .dual_mains_notch, .channel_change, .fast_settling_active, .result_valid,
    .result_ready, .result_data
);
`default_nettype wire
